/* File: dv/ssp_core_checker.sv */
`timescale 1ns/1ps
module ssp_core_checker (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire ssp_pkg::ssp_cfg_t i_cfg,
  input wire ssp_pkg::ssp_irq_t i_irq_mask,
  input wire logic              i_rd_req,
  input wire logic              o_sclk,
  input wire logic              o_sclk_oe_n,
  input wire logic              o_fss,
  input wire logic              o_fss_oe_n,
  input wire logic              o_rd_valid,
  input wire ssp_pkg::ssp_irq_t o_masked_status,
  input wire logic              o_irq
);
  import ssp_pkg::*;
  logic [1:0]  en_cnt;
  logic        steady;
  logic        mst_spi;
  logic        mst_pls;
  logic        q_sclk;
  logic        seen;
  logic [15:0] gap;
  logic [15:0] hh;
  logic [6:0]  pre_half;

  assign steady   = i_cfg.enable && (en_cnt == 2'h3);
  assign mst_spi  = steady && i_cfg.master && (i_cfg.fmt == SSP_FMT_SPI);
  assign mst_pls  = steady && i_cfg.master && (i_cfg.fmt == SSP_FMT_PULSE);
  assign pre_half = (i_cfg.prescale[7:1] == 7'h00) ?
                    7'h01 : i_cfg.prescale[7:1];
  assign hh       = 16'(pre_half) * (16'(i_cfg.rate) + 16'h0001);

  // Settling window after enable, so idle-level moves are not judged
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_cfg.enable)
      en_cnt <= 2'h0;
    else if (en_cnt != 2'h3)
      en_cnt <= en_cnt + 2'h1;
  end

  always_ff @(posedge i_clk)
  begin
    q_sclk <= o_sclk;
    if (o_sclk != q_sclk)
      gap <= 16'h0001;
    else if (gap != 16'hffff)
      gap <= gap + 16'h0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || o_fss)
      seen <= 1'b0;
    else if (o_sclk != q_sclk)
      seen <= 1'b1;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_rd_answer: assert property (i_rd_req |=> o_rd_valid)
    else $error("read request got no answer");
  a_irq_or: assert property (
    $rose(|o_masked_status) |-> ##[0:1] o_irq)
    else $error("masked source did not raise request");
  a_irq_quiet: assert property (
    (o_masked_status == 4'h0) [*2] |-> !o_irq)
    else $error("request without masked source");
  a_mask_block: assert property (
    (4'(o_masked_status) & ~4'($past(i_irq_mask))) == 4'h0)
    else $error("blocked source shows in masked status");
  a_sclk_idle: assert property (
    mst_spi && o_fss && $past(o_fss) |-> o_sclk == i_cfg.cpol)
    else $error("idle clock level wrong");
  a_fss_frame: assert property (
    mst_spi && $changed(o_sclk) |-> !o_fss)
    else $error("clock edge outside frame");
  a_half_period: assert property (
    mst_spi && seen && !o_fss && $changed(o_sclk) |-> gap == hh)
    else $error("serial half period wrong");
  a_pulse_start: assert property (
    mst_pls && $rose(o_fss) |-> $rose(o_sclk))
    else $error("frame pulse not on rising clock");
  a_pulse_end: assert property (
    mst_pls && $fell(o_fss) |-> $rose(o_sclk))
    else $error("frame pulse not one period");
  a_slave_hiz: assert property (
    steady && !i_cfg.master |-> o_sclk_oe_n && o_fss_oe_n)
    else $error("slave drives clock or frame");
endmodule

bind ssp_core ssp_core_checker ssp_core_checker_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg), .i_irq_mask(i_irq_mask),
  .i_rd_req(i_rd_req), .o_sclk(o_sclk), .o_sclk_oe_n(o_sclk_oe_n),
  .o_fss(o_fss), .o_fss_oe_n(o_fss_oe_n), .o_rd_valid(o_rd_valid),
  .o_masked_status(o_masked_status), .o_irq(o_irq)
);

/* File: dv/ssp_peer.sv */
`timescale 1ns/1ps
module ssp_peer (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cpha,
  input  wire logic        i_cmd,
  input  wire logic [3:0]  i_len_m1,
  input  wire logic [15:0] i_reply,
  input  wire logic        i_sclk,
  input  wire logic        i_fss,
  input  wire logic        i_sout,
  output logic             o_sin,
  output logic [15:0]      o_got
);
  logic       q_sclk;
  logic       q_fss;
  logic [5:0] k;
  logic [4:0] b;

  always_ff @(posedge i_clk)
  begin
    q_sclk <= i_sclk;
    q_fss  <= i_fss;
    if (i_rst)
    begin
      o_sin <= 1'b0;
      o_got <= 16'h0000;
      k     <= 6'h00;
      b     <= 5'h00;
    end
    else if (i_fss)
      // Deselected: keep the line moving so no stale bit can be read
      o_sin <= ~o_sin;
    else if (q_fss)
    begin
      k     <= 6'h00;
      o_got <= 16'h0000;
      b     <= {4'h0, ~i_cpha && !i_cmd};
      if (!i_cpha && !i_cmd)
        o_sin <= i_reply[i_len_m1];
    end
    else if (i_sclk != q_sclk)
    begin
      k <= k + 6'h01;
      if (k[0] == i_cpha)
      begin
        // Command format: only the 8 command bits are collected
        if (!i_cmd || k < 6'h10)
          o_got <= {o_got[14:0], i_sout};
      end
      // Command format: answer starts one clock after the last command bit
      else if (b <= {1'b0, i_len_m1} && (!i_cmd || k > 6'h10))
      begin
        o_sin <= i_reply[i_len_m1 - b[3:0]];
        b     <= b + 5'h01;
      end
    end
  end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import ssp_pkg::*;
  logic        i_clk, i_rst, i_wr_valid, i_rd_req, i_sclk, i_fss, i_sin;
  ssp_cfg_t    i_cfg;
  ssp_irq_t    i_irq_mask, i_irq_clr, o_raw_status, o_masked_status;
  logic [15:0] i_wr_data, o_rd_data, p_got, reply;
  logic        o_sclk, o_sclk_oe_n, o_fss, o_fss_oe_n, o_sout, o_sout_oe_n;
  logic        o_rd_valid, o_tx_full, o_rx_empty, o_busy, o_irq;
  logic        slv, t_sin, p_sin;
  logic [16:0] msk;
  int          bad_count, n_tests, m, i;
  int          cyc = 0;
  logic [3:0]  lens [4] = '{4'h7, 4'hf, 4'h3, 4'hb};
  logic [15:0] txw [4] = '{16'ha5c3, 16'h8001, 16'h000d, 16'h0b6e};
  logic [15:0] rep [4] = '{16'h3c5a, 16'hfe7f, 16'hfff2, 16'hf491};

  assign i_sin = slv ? t_sin : p_sin;

  ssp_core ssp_core_i (.i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg),
    .i_irq_mask(i_irq_mask), .i_irq_clr(i_irq_clr), .i_wr_valid(i_wr_valid),
    .i_wr_data(i_wr_data), .i_rd_req(i_rd_req), .i_sclk(i_sclk),
    .i_fss(i_fss), .i_sin(i_sin), .o_sclk(o_sclk), .o_sclk_oe_n(o_sclk_oe_n),
    .o_fss(o_fss), .o_fss_oe_n(o_fss_oe_n), .o_sout(o_sout),
    .o_sout_oe_n(o_sout_oe_n), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_tx_full(o_tx_full), .o_rx_empty(o_rx_empty), .o_busy(o_busy),
    .o_raw_status(o_raw_status), .o_masked_status(o_masked_status),
    .o_irq(o_irq));

  ssp_peer ssp_peer_i (.i_clk(i_clk), .i_rst(i_rst), .i_cpha(i_cfg.cpha),
    .i_cmd(i_cfg.fmt == SSP_FMT_CMD),
    .i_len_m1(i_cfg.word_len_m1), .i_reply(reply), .i_sclk(o_sclk),
    .i_fss(o_fss), .i_sout(o_sout), .o_sin(p_sin), .o_got(p_got));

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_b(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] d);
    i_wr_valid = 1'b1;
    i_wr_data  = d;
    tick(1);
    i_wr_valid = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [15:0] e);
    i_rd_req = 1'b1;
    tick(1);
    i_rd_req = 1'b0;
    cmp_b(o_rd_valid, 1'b1);
    cmp_w(o_rd_data, e);
    tick(1);
  endtask

  task automatic setup(input logic ms, input ssp_fmt_t f, input logic [3:0] l,
                       input logic cp, input logic ch, input logic lb);
    i_cfg = '{1'b0, ms, f, l, 8'h04, 8'h01, cp, ch, lb};
    tick(2);
    i_cfg.enable = 1'b1;
    tick(2);
  endtask

  // Done once the clock has rested for longer than any in-frame pause
  task automatic wait_idle;
    int q;
    int k;
    logic s;
    q = 0;
    s = o_sclk;
    for (k = 0; k < 3000 && q < 16; k++)
    begin
      tick(1);
      q = (o_busy === 1'b0 && o_sclk === s) ? q + 1 : 0;
      s = o_sclk;
    end
    cmp_b(o_busy, 1'b0);
  endtask

  // Slave frame at one sixteenth of the system clock
  task automatic sframe(input logic [7:0] w);
    int j;
    i_fss = 1'b0;
    tick(8);
    for (j = 7; j >= 0; j--)
    begin
      t_sin = w[j];
      tick(8);
      i_sclk = 1'b1;
      tick(8);
      i_sclk = 1'b0;
    end
    tick(8);
    i_fss = 1'b1;
  endtask

  always @(posedge i_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    {i_rst, i_fss} = 2'b11;
    {i_wr_valid, i_rd_req, i_sclk, slv, t_sin} = 5'h00;
    i_cfg = '0;
    i_irq_mask = '0;
    i_irq_clr = '0;
    i_wr_data = 16'h0000;
    reply = 16'h0000;
    {bad_count, n_tests} = '0;
    tick(4);
    i_rst = 1'b0;
    tick(2);
    cmp_b(o_raw_status.tx_svc, 1'b1);
    cmp_b(o_irq, 1'b0);
    for (m = 0; m < 4; m++)
    begin
      setup(1'b1, SSP_FMT_SPI, lens[m], m[1], m[0], 1'b0);
      reply = rep[m];
      msk = (17'h0_0001 << (5'(lens[m]) + 5'h01)) - 17'h0_0001;
      wr(txw[m]);
      wait_idle();
      cmp_w(p_got, txw[m] & msk[15:0]);
      cmp_b(o_sclk, m[1]);
      rd(reply & msk[15:0]);
    end
    setup(1'b1, SSP_FMT_PULSE, 4'hf, 1'b0, 1'b0, 1'b1);
    wr(16'ha5c3);
    wr(16'h3c5a);
    wait_idle();
    cmp_b(o_sout_oe_n, 1'b1);
    cmp_b(o_fss | o_sclk, 1'b0);
    cmp_b(o_sclk_oe_n | o_fss_oe_n, 1'b0);
    rd(16'ha5c3);
    rd(16'h3c5a);
    setup(1'b1, SSP_FMT_CMD, 4'hb, 1'b0, 1'b0, 1'b1);
    wr(16'h00ff);
    wait_idle();
    cmp_b(o_rx_empty, 1'b0);
    rd(16'h0000);
    setup(1'b1, SSP_FMT_CMD, 4'hb, 1'b0, 1'b0, 1'b0);
    reply = 16'h0a5c;
    wr(16'h1234);
    wait_idle();
    cmp_w(p_got, 16'h0034);
    rd(16'h0a5c);
    setup(1'b1, SSP_FMT_SPI, 4'h3, 1'b0, 1'b0, 1'b1);
    for (i = 1; i <= 8; i++)
      wr(16'(i));
    wait_idle();
    cmp_b(o_raw_status.rx_svc, 1'b1);
    cmp_b(o_raw_status.overrun, 1'b0);
    wr(16'h0009);
    wait_idle();
    cmp_b(o_raw_status.overrun, 1'b1);
    i_irq_mask = '{1'b1, 1'b0, 1'b0, 1'b0};
    tick(3);
    cmp_b(o_irq, 1'b1);
    cmp_b(o_masked_status.tx_svc, 1'b0);
    cmp_b(o_raw_status.tx_svc, 1'b1);
    for (i = 1; i <= 8; i++)
      rd(16'(i));
    i_irq_clr = '{1'b1, 1'b1, 1'b0, 1'b0};
    tick(1);
    i_irq_clr = '0;
    tick(3);
    cmp_b(o_irq, 1'b0);
    wr(16'h0006);
    wait_idle();
    cmp_b(o_raw_status.timeout, 1'b0);
    tick(300);
    cmp_b(o_raw_status.timeout, 1'b1);
    rd(16'h0006);
    setup(1'b0, SSP_FMT_SPI, 4'h7, 1'b0, 1'b0, 1'b0);
    for (i = 0; i < 8; i++)
      wr(16'(i));
    cmp_b(o_tx_full, 1'b1);
    slv = 1'b1;
    sframe(8'h9d);
    tick(4);
    rd(16'h009d);
    complete_run();
  end
endmodule

/* File: rtl/ssp_core.sv */
`timescale 1ns/1ps
module ssp_core (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire ssp_pkg::ssp_cfg_t i_cfg,
  input  wire ssp_pkg::ssp_irq_t i_irq_mask,
  input  wire ssp_pkg::ssp_irq_t i_irq_clr,
  input  wire logic             i_wr_valid,
  input  wire logic [15:0]      i_wr_data,
  input  wire logic             i_rd_req,
  input  wire logic             i_sclk,
  input  wire logic             i_fss,
  input  wire logic             i_sin,
  output logic                  o_sclk,
  output logic                  o_sclk_oe_n,
  output logic                  o_fss,
  output logic                  o_fss_oe_n,
  output logic                  o_sout,
  output logic                  o_sout_oe_n,
  output logic [15:0]           o_rd_data,
  output logic                  o_rd_valid,
  output logic                  o_tx_full,
  output logic                  o_rx_empty,
  output logic                  o_busy,
  output ssp_pkg::ssp_irq_t     o_raw_status,
  output ssp_pkg::ssp_irq_t     o_masked_status,
  output logic                  o_irq
);
  import ssp_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_SHIFT,
    ST_TAIL
  } ssp_state_t;

  ssp_state_t  state;
  logic [5:0]  k;
  logic        lead;
  logic [6:0]  pre_cnt;
  logic [7:0]  rate_cnt;
  logic [6:0]  half_pre;
  logic        pre_tick;
  logic        half_tick;
  logic        is_spi;
  logic        is_pulse;
  logic        is_cmd;
  logic [3:0]  len_m1;
  logic [3:0]  msb_idx;
  logic [5:0]  last_k;
  logic        cpha_eff;
  logic        idle_clk;
  logic        idle_fss;
  logic        sclk_prev;
  logic        fss_prev;
  logic        slave_edge;
  logic        slave_start;
  logic        master_start;
  logic        load;
  logic        edge_ev;
  logic        cap;
  logic        launch;
  logic        rx_bit;
  logic        done;
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic [15:0] rx_hold;
  logic        rx_push_q;
  logic [15:0] next_load;
  logic [15:0] tx_head;
  logic [15:0] rx_head;
  logic [3:0]  tx_count;
  logic [3:0]  rx_count;
  logic        tx_full;
  logic        tx_empty;
  logic        rx_full;
  logic        rx_empty;
  logic        rx_pop;
  logic        tx_pop;
  logic        overrun;
  logic        timeout;
  logic [6:0]  tmo_cnt;
  logic        tmo_run;
  logic        tmo_hit;
  ssp_irq_t    next_raw;

  // Format decode and word geometry
  assign is_spi   = (i_cfg.fmt == SSP_FMT_SPI);
  assign is_pulse = (i_cfg.fmt == SSP_FMT_PULSE);
  assign is_cmd   = (i_cfg.fmt == SSP_FMT_CMD);
  assign len_m1   = (i_cfg.word_len_m1 < SSP_MIN_LEN_M1) ?
                    SSP_MIN_LEN_M1 : i_cfg.word_len_m1;
  assign msb_idx  = is_cmd ? SSP_CMD_MSB : len_m1;
  assign last_k   = {1'b0, len_m1, 1'b1} +
                    (is_cmd ? SSP_RESP_EDGE : 6'h00);
  assign cpha_eff = is_spi ? i_cfg.cpha : is_pulse;
  assign idle_clk = is_spi ? i_cfg.cpol : 1'b0;
  assign idle_fss = !is_pulse;

  // Two-stage bit-rate divider; half_tick marks each half serial period
  assign half_pre  = (i_cfg.prescale[7:1] == 7'h00) ?
                     7'h01 : i_cfg.prescale[7:1];
  assign pre_tick  = i_cfg.enable && (pre_cnt == half_pre - 7'h01);
  assign half_tick = pre_tick && (rate_cnt == i_cfg.rate);

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_cfg.enable)
    begin
      pre_cnt  <= 7'h00;
      rate_cnt <= 8'h00;
    end
    else if (pre_tick)
    begin
      pre_cnt  <= 7'h00;
      rate_cnt <= (rate_cnt == i_cfg.rate) ? 8'h00 : rate_cnt + 8'h01;
    end
    else
    begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // Slave side edge detection on the incoming clock and frame
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sclk_prev <= 1'b0;
      fss_prev  <= 1'b1;
    end
    else
    begin
      sclk_prev <= i_sclk;
      fss_prev  <= i_fss;
    end
  end

  assign slave_edge   = (i_sclk != sclk_prev);
  assign slave_start  = i_cfg.enable && !i_cfg.master && state == ST_IDLE &&
                        (is_pulse ? (slave_edge && !i_sclk && i_fss)
                                  : (fss_prev && !i_fss));
  assign master_start = i_cfg.enable && i_cfg.master && state == ST_IDLE &&
                        !tx_empty && half_tick;
  assign load         = master_start || slave_start;
  assign tx_pop       = load && !tx_empty;
  assign edge_ev      = (state == ST_SHIFT) &&
                        (i_cfg.master ? half_tick : slave_edge);
  assign cap          = edge_ev && (k[0] == cpha_eff) &&
                        (!is_cmd || k >= SSP_RESP_EDGE);
  assign launch       = edge_ev && (k[0] != cpha_eff) && (k != 6'h00) &&
                        (!is_cmd || k < SSP_CMD_EDGES);
  assign rx_bit       = i_cfg.loopback ? o_sout : i_sin;
  assign done         = (state == ST_TAIL) &&
                        (i_cfg.master ? half_tick : 1'b1);
  assign next_load    = tx_empty ? SSP_WORD_RST :
                        (is_cmd ? (tx_head & SSP_CMD_MASK) : tx_head);

  // Frame sequencer, serial clock and frame line
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state  <= ST_IDLE;
      k      <= 6'h00;
      lead   <= 1'b0;
      o_sclk <= 1'b0;
      o_fss  <= 1'b1;
    end
    else if (!i_cfg.enable)
    begin
      state  <= ST_IDLE;
      k      <= 6'h00;
      lead   <= 1'b0;
      o_sclk <= idle_clk;
      o_fss  <= idle_fss;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          o_sclk <= idle_clk;
          o_fss  <= idle_fss;
          k      <= 6'h00;
          lead   <= 1'b0;
          if (master_start)
          begin
            o_fss <= 1'b0;
            state <= ST_LEAD;
          end
          else if (slave_start)
          begin
            state <= ST_SHIFT;
          end
        end
        ST_LEAD:
        begin
          if (half_tick)
          begin
            if (!is_pulse)
            begin
              state <= ST_SHIFT;
            end
            else
            begin
              o_sclk <= !o_sclk;
              lead   <= 1'b1;
              if (!lead)
              begin
                o_fss <= 1'b1;
              end
              else
              begin
                state <= ST_SHIFT;
              end
            end
          end
        end
        ST_SHIFT:
        begin
          if (!i_cfg.master && !is_pulse && i_fss)
          begin
            state <= ST_IDLE;
          end
          else if (edge_ev)
          begin
            k <= k + 6'h01;
            if (i_cfg.master)
            begin
              o_sclk <= !o_sclk;
            end
            if (i_cfg.master && is_pulse && k == 6'h00)
            begin
              o_fss <= 1'b0;
            end
            if (k == last_k)
            begin
              state <= ST_TAIL;
            end
          end
        end
        ST_TAIL:
        begin
          if (done)
          begin
            o_fss <= idle_fss;
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Transmit and receive shifters
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_sh  <= SSP_WORD_RST;
      rx_sh  <= SSP_WORD_RST;
      o_sout <= 1'b0;
    end
    else if (load)
    begin
      tx_sh  <= next_load;
      o_sout <= next_load[msb_idx];
      rx_sh  <= SSP_WORD_RST;
    end
    else
    begin
      if (launch)
      begin
        tx_sh  <= tx_sh << 1;
        o_sout <= tx_sh[msb_idx - 4'h1];
      end
      else if (state == ST_IDLE)
      begin
        o_sout <= 1'b0;
      end
      if (cap)
      begin
        rx_sh <= {rx_sh[14:0], rx_bit};
      end
    end
  end

  // Pad enables, low while driving
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_sclk_oe_n <= 1'b1;
      o_fss_oe_n  <= 1'b1;
      o_sout_oe_n <= 1'b1;
    end
    else
    begin
      o_sclk_oe_n <= !(i_cfg.enable && i_cfg.master);
      o_fss_oe_n  <= !(i_cfg.enable && i_cfg.master);
      if (i_cfg.master)
      begin
        o_sout_oe_n <= !(i_cfg.enable &&
                         !(is_pulse && state == ST_IDLE));
      end
      else
      begin
        o_sout_oe_n <= !(i_cfg.enable && state != ST_IDLE);
      end
    end
  end

  // Completed word is held one cycle before the FIFO load
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rx_hold   <= SSP_WORD_RST;
      rx_push_q <= 1'b0;
    end
    else
    begin
      rx_push_q <= done;
      if (done)
      begin
        rx_hold <= rx_sh;
      end
    end
  end

  assign rx_pop = i_rd_req && !rx_empty;

  ssp_fifo #(
    .WIDTH (SSP_WIDTH),
    .DEPTH (SSP_DEPTH)
  ) u_tx_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_push  (i_wr_valid),
    .i_data  (i_wr_data),
    .i_pop   (tx_pop),
    .o_data  (tx_head),
    .o_count (tx_count),
    .o_full  (tx_full),
    .o_empty (tx_empty)
  );

  ssp_fifo #(
    .WIDTH (SSP_WIDTH),
    .DEPTH (SSP_DEPTH)
  ) u_rx_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_push  (rx_push_q),
    .i_data  (rx_hold),
    .i_pop   (rx_pop),
    .o_data  (rx_head),
    .o_count (rx_count),
    .o_full  (rx_full),
    .o_empty (rx_empty)
  );

  // CPU read answer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_rd_data  <= SSP_WORD_RST;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_req;
      o_rd_data  <= rx_empty ? SSP_WORD_RST : rx_head;
    end
  end

  // Receive timeout counts idle half periods while data waits
  assign tmo_run = !rx_empty && state == ST_IDLE && !rx_push_q && !rx_pop;
  assign tmo_hit = tmo_run && half_tick &&
                   (tmo_cnt == SSP_TMO_HALVES - 7'h01);

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !tmo_run)
    begin
      tmo_cnt <= 7'h00;
    end
    else if (half_tick && tmo_cnt != SSP_TMO_HALVES)
    begin
      tmo_cnt <= tmo_cnt + 7'h01;
    end
  end

  // Sticky event flags; a new event beats a clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      overrun <= 1'b0;
      timeout <= 1'b0;
    end
    else
    begin
      if (rx_push_q && rx_full)
      begin
        overrun <= 1'b1;
      end
      else if (i_irq_clr.overrun)
      begin
        overrun <= 1'b0;
      end
      if (tmo_hit)
      begin
        timeout <= 1'b1;
      end
      else if (i_irq_clr.timeout)
      begin
        timeout <= 1'b0;
      end
    end
  end

  always_comb
  begin
    next_raw         = SSP_IRQ_RST;
    next_raw.overrun = overrun || (rx_push_q && rx_full);
    next_raw.timeout = timeout || tmo_hit;
    next_raw.rx_svc  = (rx_count >= SSP_HALF_LEVEL);
    next_raw.tx_svc  = (tx_count <= SSP_HALF_LEVEL);
  end

  // Status and request outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_raw_status    <= SSP_IRQ_RST;
      o_masked_status <= SSP_IRQ_RST;
      o_irq           <= 1'b0;
      o_tx_full       <= 1'b0;
      o_rx_empty      <= 1'b1;
      o_busy          <= 1'b0;
    end
    else
    begin
      o_raw_status    <= next_raw;
      o_masked_status <= next_raw & i_irq_mask;
      o_irq           <= |(next_raw & i_irq_mask);
      o_tx_full       <= tx_full;
      o_rx_empty      <= rx_empty;
      o_busy          <= (state != ST_IDLE) || !tx_empty;
    end
  end
endmodule

/* File: rtl/ssp_fifo.sv */
`timescale 1ns/1ps
module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_push,
  input  wire logic [WIDTH-1:0]           i_data,
  input  wire logic                       i_pop,
  output logic      [WIDTH-1:0]           o_data,
  output logic      [$clog2(DEPTH):0]     o_count,
  output logic                            o_full,
  output logic                            o_empty
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             do_push;
  logic             do_pop;

  assign o_full  = (count == (PW+1)'(DEPTH));
  assign o_empty = (count == '0);
  assign do_push = i_push && !o_full;
  assign do_pop  = i_pop && !o_empty;
  assign o_data  = mem[rd_ptr];
  assign o_count = count;

  always_ff @(posedge i_clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* File: rtl/ssp_pkg.sv */
package ssp_pkg;

  localparam int          SSP_WIDTH       = 16;
  localparam int          SSP_DEPTH       = 8;
  localparam logic [3:0]  SSP_HALF_LEVEL  = 4'h4;
  localparam logic [3:0]  SSP_MIN_LEN_M1  = 4'h3;
  localparam logic [3:0]  SSP_CMD_MSB     = 4'h7;
  localparam logic [15:0] SSP_CMD_MASK    = 16'h00FF;
  localparam logic [5:0]  SSP_CMD_EDGES   = 6'h10;
  localparam logic [5:0]  SSP_RESP_EDGE   = 6'h12;
  localparam logic [6:0]  SSP_TMO_HALVES  = 7'h40;
  localparam logic [15:0] SSP_WORD_RST    = 16'h0000;
  localparam logic [3:0]  SSP_IRQ_RST     = 4'h0;

  typedef enum logic [1:0] {
    SSP_FMT_SPI,
    SSP_FMT_PULSE,
    SSP_FMT_CMD
  } ssp_fmt_t;

  typedef struct packed {
    logic       enable;
    logic       master;
    ssp_fmt_t   fmt;
    logic [3:0] word_len_m1;
    logic [7:0] prescale;
    logic [7:0] rate;
    logic       cpol;
    logic       cpha;
    logic       loopback;
  } ssp_cfg_t;

  typedef struct packed {
    logic overrun;
    logic timeout;
    logic rx_svc;
    logic tx_svc;
  } ssp_irq_t;

endpackage
